// File: sacr_ctrl.sv
// Conversion sequencer and serial result shifter
`default_nettype none
module sacr_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic convert_strobe,
  input wire logic din,
  input wire logic sclk,
  input wire logic [17:0] sample_code,
  output logic dout,
  output logic dout_oe,
  output logic sample_hold,
  output logic inputs_connected,
  output logic powered_down,
  output logic daisy_mode
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change counts when stages two and three agree
  logic [2:0] cnv_sy_r, din_sy_r, sck_sy_r;
  logic cnv_q_r, din_q_r, sck_q_r;
  logic cnv_q_nxt, din_q_nxt, sck_q_nxt;

  always_comb begin
    cnv_q_nxt = (cnv_sy_r[1] == cnv_sy_r[2]) ? cnv_sy_r[2] : cnv_q_r;
    din_q_nxt = (din_sy_r[1] == din_sy_r[2]) ? din_sy_r[2] : din_q_r;
    sck_q_nxt = (sck_sy_r[1] == sck_sy_r[2]) ? sck_sy_r[2] : sck_q_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnv_sy_r <= 3'h0;
      din_sy_r <= 3'h7;
      sck_sy_r <= 3'h0;
      cnv_q_r <= 1'b0;
      din_q_r <= 1'b1;
      sck_q_r <= 1'b0;
    end else begin
      cnv_sy_r <= {cnv_sy_r[1:0], convert_strobe};
      din_sy_r <= {din_sy_r[1:0], din};
      sck_sy_r <= {sck_sy_r[1:0], sclk};
      cnv_q_r <= cnv_q_nxt;
      din_q_r <= din_q_nxt;
      sck_q_r <= sck_q_nxt;
    end
  end

  logic cnv_rise, sck_fall, cs_n;
  assign cnv_rise = cnv_q_nxt & ~cnv_q_r;
  assign sck_fall = ~sck_q_nxt & sck_q_r;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  sacr_pkg::sacr_state_e state_r, state_nxt;
  logic [8:0] conv_cnt_r, conv_cnt_nxt;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [17:0] result_r, result_nxt, shift_r, shift_nxt;
  logic daisy_r, daisy_nxt, oe_r, oe_nxt, out_r, out_nxt;

  // Three-wire: strobe is select; four-wire: the serial input is select
  assign cs_n = daisy_r ? 1'b0 : (cnv_q_r & din_q_r);

  // Next-state logic; the conversion length comes only from the local clock
  always_comb begin
    state_nxt = state_r;
    conv_cnt_nxt = conv_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    result_nxt = result_r;
    shift_nxt = shift_r;
    daisy_nxt = daisy_r;
    oe_nxt = oe_r;
    out_nxt = out_r;
    unique case (state_r)
      sacr_pkg::SACR_ACQ, sacr_pkg::SACR_READ: begin
        if (cnv_rise) begin
          state_nxt = sacr_pkg::SACR_CONV;
          daisy_nxt = ~din_q_r;
          result_nxt = sample_code;
          conv_cnt_nxt = sacr_pkg::CONV_CNT_RST;
          oe_nxt = 1'b0; // Strobe edge forces the output off
        end else if (state_r == sacr_pkg::SACR_ACQ) begin
          // Readout opens only in acquisition, on select low
          if (!cs_n) begin
            state_nxt = sacr_pkg::SACR_READ;
            shift_nxt = result_r;
            out_nxt = result_r[17];
            oe_nxt = 1'b1;
            bit_cnt_nxt = 5'h00;
          end
        end else if (cs_n) begin
          oe_nxt = 1'b0;
          state_nxt = sacr_pkg::SACR_ACQ;
        end else if (sck_fall && oe_r) begin
          if (bit_cnt_r == sacr_pkg::LAST_BIT) begin
            oe_nxt = 1'b0;
          end else begin
            shift_nxt = {shift_r[16:0], daisy_r ? din_q_r : 1'b0};
            out_nxt = shift_r[16];
            bit_cnt_nxt = bit_cnt_r + 5'h01;
          end
        end
      end
      sacr_pkg::SACR_CONV: begin
        // Serial clock is not looked at here
        if (conv_cnt_r == 9'(sacr_pkg::CONV_CYCLES - 1)) begin
          state_nxt = sacr_pkg::SACR_ACQ;
        end else begin
          conv_cnt_nxt = conv_cnt_r + 9'h001;
        end
      end
      default: state_nxt = sacr_pkg::SACR_ACQ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sacr_pkg::SACR_ACQ;
      conv_cnt_r <= sacr_pkg::CONV_CNT_RST;
      bit_cnt_r <= 5'h00;
      result_r <= sacr_pkg::RESULT_RST;
      shift_r <= sacr_pkg::RESULT_RST;
      daisy_r <= 1'b0;
      oe_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      result_r <= result_nxt;
      shift_r <= shift_nxt;
      daisy_r <= daisy_nxt;
      oe_r <= oe_nxt;
      out_r <= out_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dout = out_r;
  assign dout_oe = oe_r;
  assign daisy_mode = daisy_r;
  assign sample_hold = (state_r == sacr_pkg::SACR_CONV);
  assign inputs_connected = (state_r != sacr_pkg::SACR_CONV);
  assign powered_down = (state_r != sacr_pkg::SACR_CONV);

  //////////////////////////////////////////////////////////////////////////////
  // Conversion age counter for the checks only
  // Kept apart from the sequencer counter, so a wrong end compare there
  // still shows up as a too long or too short conversion
  logic [9:0] conv_age_r, conv_age_nxt;

  // Zero outside conversion, one step per cycle inside it
  always_comb begin
    conv_age_nxt = 10'h000;
    if (state_r == sacr_pkg::SACR_CONV) begin
      conv_age_nxt = conv_age_r + 10'h001;
    end
  end

  // Age register, same reset as the sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_age_r <= 10'h000;
    end else begin
      conv_age_r <= conv_age_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence conv_start_s;
    cnv_rise && state_r != sacr_pkg::SACR_CONV;
  endsequence
  sequence oe_off_s;
    !dout_oe;
  endsequence

  conv_starts_a: assert property (@(posedge clk) disable iff (rst)
    conv_start_s |=> state_r == sacr_pkg::SACR_CONV)
    else $error("conversion not started by strobe edge");
  mode_pick_a: assert property (@(posedge clk) disable iff (rst)
    conv_start_s |=> daisy_r == !$past(din_q_r))
    else $error("mode not taken from serial input");
  mode_hold_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_CONV && !$past(cnv_rise) |-> $stable(daisy_r))
    else $error("mode changed during conversion");
  conv_quiet_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_CONV |-> !dout_oe)
    else $error("output driven during conversion");
  input_discon_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_CONV |-> !inputs_connected && !powered_down)
    else $error("inputs connected while converting");
  conv_length_a: assert property (@(posedge clk) disable iff (rst)
    conv_start_s |=> (state_r == sacr_pkg::SACR_CONV) [*8])
    else $error("conversion ended too early");
  acq_after_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_CONV && state_nxt != sacr_pkg::SACR_CONV
    |=> inputs_connected && powered_down)
    else $error("no acquisition after conversion");
  msb_first_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_ACQ && !cnv_rise && !cs_n |=> dout_oe && dout == result_r[17])
    else $error("msb not presented on select");
  read_acq_a: assert property (@(posedge clk) disable iff (rst)
    dout_oe |-> powered_down)
    else $error("read outside acquisition");
  release_cs_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_READ && cs_n |=> oe_off_s)
    else $error("output not released on select high");
  release_18_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_READ && sck_fall && bit_cnt_r == sacr_pkg::LAST_BIT |=> oe_off_s)
    else $error("output not released after last bit");
  shift_step_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_READ && !cs_n && !cnv_rise && oe_r && !sck_fall
    |=> $stable(dout))
    else $error("output changed without serial clock fall");
  // Conversion length against the independent age count
  conv_full_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_CONV && conv_age_r < 10'(sacr_pkg::CONV_CYCLES - 1)
    |=> state_r == sacr_pkg::SACR_CONV)
    else $error("conversion cut short");
  conv_end_a: assert property (@(posedge clk) disable iff (rst)
    state_r == sacr_pkg::SACR_CONV && conv_age_r == 10'(sacr_pkg::CONV_CYCLES - 1)
    |=> state_r != sacr_pkg::SACR_CONV)
    else $error("conversion overran its length");
endmodule // sacr_ctrl
`default_nettype wire

// File: sacr_host.sv
// Host model driving convert strobe, select line and serial clock
`default_nettype none
module sacr_host (
  input wire logic clk,
  output logic convert_strobe,
  output logic din,
  output logic sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Serial clock idles low between frames; daisy mode needs din low at strobe rise
  initial begin
    convert_strobe = 1'b0;
    din = 1'b1;
    sclk = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Mode level settles on din well before the strobe rises
  task automatic start(input logic cs_mode);
    @(posedge clk);
    din <= cs_mode;
    wait_clk(2);
    convert_strobe <= 1'b0;
    wait_clk(4);
    convert_strobe <= 1'b1;
  endtask
  // One link clock period of 160 ns, rise then fall
  task automatic pulse();
    sclk <= 1'b1;
    wait_clk(4);
    sclk <= 1'b0;
    wait_clk(4);
  endtask
  // Select low: strobe in three-wire, din in four-wire
  task automatic select(input logic three_wire);
    if (three_wire) convert_strobe <= 1'b0;
    else din <= 1'b0;
  endtask
  task automatic deselect();
    convert_strobe <= 1'b1;
    din <= 1'b1;
  endtask
endmodule // sacr_host
`default_nettype wire

// File: sacr_pkg.sv
// Package for the converter control and serial readout block
// Behaviour
// - The convert strobe rising edge starts a conversion, and in the three-wire setup it is also the active-low readout select.
// - The serial input level at conversion start picks chip-select or daisy-chain mode for that cycle.
// - In the four-wire setup the serial input line is the active-low select that gates readout.
// - Result bits leave on the serial output in step with the host serial clock.
// - Conversions are timed by the internal oscillator, never by the serial clock.
// - At conversion start the differential input is captured onto the sampling array.
// - Both analog inputs stay disconnected from the sampling circuit for the whole conversion.
// - At conversion end the sampling capacitors reconnect and acquisition begins.
// - During acquisition the device is powered down, and only then may the result be read.
// - Serial input low at the strobe rising edge selects daisy-chain mode, high selects chip-select mode.
// - The MSB appears when select falls, and each lower bit follows on a later falling serial clock edge.
// - The serial output goes high impedance after the 18th falling serial clock edge or when select rises first.
// - Results are in two's complement.
`default_nettype none
package sacr_pkg;
  localparam int unsigned RES_BITS = 18;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CONV_TIME_NS = 8800;
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [4:0] LAST_BIT = 5'h11;
  localparam logic [8:0] CONV_CNT_RST = 9'h000;
  localparam logic [RES_BITS-1:0] RESULT_RST = 18'h0_0000;

  typedef enum logic [2:0] {
    SACR_ACQ = 3'b001,
    SACR_CONV = 3'b010,
    SACR_READ = 3'b100
  } sacr_state_e;

  typedef struct packed {
    logic dout;
    logic dout_oe;
  } sacr_serial_out_s;
endpackage
`default_nettype wire

// File: sar_adc_convert_readout_ctrl_test.sv
// Self-checking bench for the converter sequencer and readout
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sar_adc_convert_readout_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic [17:0] sample_code;
  logic convert_strobe, din, sclk, dout, dout_oe;
  logic sample_hold, inputs_connected, powered_down, daisy_mode;
  int compares = 0;
  int miscompares = 0;
  // Reference queue of captured codes, oldest first
  logic [17:0] model_q[$];
  initial clk = 1'b0;
  always #10 clk = ~clk;
  sacr_host host (.clk(clk), .convert_strobe(convert_strobe), .din(din), .sclk(sclk));
  sacr_ctrl DUT (.clk(clk), .rst(rst), .convert_strobe(convert_strobe), .din(din),
    .sclk(sclk), .sample_code(sample_code), .dout(dout), .dout_oe(dout_oe),
    .sample_hold(sample_hold), .inputs_connected(inputs_connected),
    .powered_down(powered_down), .daisy_mode(daisy_mode));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Mode 0 four-wire, 1 three-wire, 2 daisy; fewer than 18 bits ends early
  task automatic run(input int mode, input int nbits);
    logic [17:0] code;
    logic [17:0] exp;
    code = 18'($urandom);
    @(posedge clk);
    sample_code <= code;
    model_q.push_back(code);
    host.start(mode != 2);
    host.wait_clk(6);
    `CHK(sample_hold, 1'b1)
    `CHK(inputs_connected, 1'b0)
    `CHK(powered_down, 1'b0)
    `CHK(daisy_mode, (mode == 2))
    sample_code <= ~code;
    // Clocks during conversion must not shift anything
    host.pulse();
    host.pulse();
    `CHK(dout_oe, 1'b0)
    host.wait_clk(440);
    `CHK(inputs_connected, 1'b1)
    `CHK(powered_down, 1'b1)
    exp = model_q.pop_front();
    if (mode != 2) host.select(mode == 1);
    for (int i = 0; i < nbits; i++) begin
      if (i > 0) host.pulse();
      else host.wait_clk(4);
      host.wait_clk(4);
      `CHK(dout_oe, 1'b1)
      `CHK(dout, exp[17-i])
    end
    if (nbits == 18 && mode != 2) begin
      host.pulse();
      host.wait_clk(4);
      `CHK(dout_oe, 1'b0)
    end else if (mode != 2) begin
      host.deselect();
      host.wait_clk(8);
      `CHK(dout_oe, 1'b0)
      if (mode == 1) `CHK(sample_hold, 1'b1)
    end
    host.deselect();
    // A three-wire deselect is a strobe rise: let that conversion run out
    host.wait_clk(mode == 1 ? 450 : 8);
    $display("test mode %0d bits %0d done", mode, nbits);
  endtask
  // Main sequence: full reads in each mode, then early deselects
  initial begin
    rst <= 1'b1;
    sample_code <= 18'h0_0000;
    void'($urandom(32'h58cf538d));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.wait_clk(6);
    for (int m = 0; m < 3; m++) run(m, 18);
    run(0, 5);
    run(1, 7);
    summarize();
  end
  // Watchdog well beyond seven conversions
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
endmodule // sar_adc_convert_readout_ctrl_test
`default_nettype wire
